// ---- dv/tb.sv ----
// Self-checking bench for the fan monitor configuration register slice.
// Assumes the APB slave answers with pready; read data valid at the access edge.
`timescale 1ns/1ps
`default_nettype none
`include "fmcr_map.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
	localparam logic [11:0] A_FMT  = {2'b00, `FMCR_IDX_FMT_DRIVE, 2'b00};
	localparam logic [11:0] A_PIN  = {2'b00, `FMCR_IDX_PIN_SCALE, 2'b00};
	localparam logic [11:0] A_TA   = {2'b00, `FMCR_IDX_TEST_A, 2'b00};
	localparam logic [11:0] A_TB   = {2'b00, `FMCR_IDX_TEST_B, 2'b00};
	localparam logic [11:0] A_LOCK = {2'b00, `FMCR_IDX_LOCK, 2'b00};
	logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdv;
	logic [3:0]  pstrb = 0, bypass;
	logic        pready, pslverr, errv, low_freq, thr_act, pin_out, pin_oe, gp_in, fan4_in;
	logic        gp = 0, al = 0, th = 0, pin = 0;
	logic [1:0]  thr;
	logic [23:0] temp_raw = 24'h8019e7, temp_view;
	int          errors = 0, cmp_count = 0;
	fmcr_regs #(.TEMP_N(3)) u_dut (.i_ref_clk(clk), .i_reset_n(reset_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_pstrb(pstrb), .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
		.i_temp_raw(temp_raw), .o_temp_view(temp_view), .o_drive_low_freq(low_freq),
		.o_two_wire_sense_threshold(thr), .o_threshold_active(thr_act),
		.o_bypass_atten(bypass), .i_gp_level(gp), .i_alert_level(al),
		.i_thermal_drive(th), .i_pin_in(pin), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
		.o_gp_in(gp_in), .o_fan4_in(fan4_in));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test
	// Setup, access until pready, take data at that edge, release
	task automatic apb(input logic we, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1; pwrite <= we; paddr <= a; pwdata <= {24'h000000, d}; pstrb <= 4'hf;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 20) begin errors++; stop_test(); end
			@(posedge clk);
		end
		errv = pslverr;
		rdv = prdata;
		psel <= 1'b0; penable <= 1'b0; pstrb <= 4'h0;
		@(negedge clk);
	endtask : apb
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 8'h00);
		`CHK("read data", e, rdv)
	endtask : rd_chk
	task automatic t_reset();
		rd_chk(A_FMT, 32'h0);
		rd_chk(A_PIN, 32'h0);
		rd_chk(A_TB, 32'h0);
		`CHK("outputs", 8'h00, {low_freq, thr_act, thr, bypass})
		$display("test reset done");
	endtask : t_reset
	task automatic t_fmt();
		apb(1'b1, A_FMT, 8'hff);
		rd_chk(A_FMT, 32'h0000000f);
		`CHK("low freq", 2'b11, {low_freq, thr_act})
		`CHK("view twos", 24'h8019e7, temp_view)
		apb(1'b1, A_FMT, 8'h00);
		`CHK("view off64", 24'hc05927, temp_view)
		`CHK("high freq", 2'b00, {low_freq, thr_act})
		$display("test format done");
	endtask : t_fmt
	// exp = {out, oe, gp_in, fan4_in}; src = {gp, alert, thermal, pin}
	task automatic pin_chk(input logic [7:0] f, input logic [7:0] p, input logic [3:0] src,
		input logic [3:0] e);
		apb(1'b1, A_FMT, f);
		apb(1'b1, A_PIN, p);
		@(posedge clk);
		{gp, al, th, pin} <= src;
		@(negedge clk);
		`CHK("shared pin", e, {pin_out, pin_oe, gp_in, fan4_in})
	endtask : pin_chk
	task automatic t_pin();
		pin_chk(8'h00, 8'h00, 4'h1, 4'b0001);
		pin_chk(8'h00, 8'h01, 4'h2, 4'b0100);
		pin_chk(8'h00, 8'h01, 4'hd, 4'b0000);
		pin_chk(8'h00, 8'h02, 4'h4, 4'b0100);
		pin_chk(8'h00, 8'h03, 4'h1, 4'b0010);
		pin_chk(8'h0c, 8'h03, 4'h8, 4'b1100);
		pin_chk(8'h04, 8'h03, 4'h8, 4'b0100);
		pin_chk(8'h02, 8'ha6, 4'h0, 4'b0000);
		`CHK("thr bypass", 7'h5a, {thr_act, thr, bypass})
		rd_chk(A_PIN, 32'h000000a6);
		$display("test pin done");
	endtask : t_pin
	task automatic t_test_regs();
		apb(1'b1, A_TA, 8'h5a);
		rd_chk(A_TA, 32'h0);
		apb(1'b1, A_TB, 8'ha5);
		rd_chk(A_TB, 32'h0);
		apb(1'b0, 12'h400, 8'h00);
		`CHK("unmapped", 33'h100000000, {errv, rdv})
		$display("test reserved done");
	endtask : t_test_regs
	task automatic t_lock();
		apb(1'b1, A_FMT, 8'h03);
		apb(1'b1, A_PIN, 8'h5b);
		apb(1'b1, A_LOCK, 8'h01);
		apb(1'b1, A_FMT, 8'h0c);
		apb(1'b1, A_PIN, 8'ha4);
		rd_chk(A_FMT, 32'h00000003);
		rd_chk(A_PIN, 32'h0000005b);
		`CHK("locked outs", 7'h65, {low_freq, thr, bypass})
		$display("test lock done");
	endtask : t_lock
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_fmt();
		t_pin();
		t_test_regs();
		t_lock();
		stop_test();
	end
endmodule : tb
`default_nettype wire

// ---- verilog/fmcr_map.svh ----
// Constants for the fan monitor configuration register slice.
// Assumes a 32-bit APB master; registers sit at word index times four.
`ifndef FMCR_MAP_SVH
`define FMCR_MAP_SVH
`define FMCR_IDX_FMT_DRIVE   8'h7c
`define FMCR_IDX_PIN_SCALE   8'h7d
`define FMCR_IDX_TEST_A      8'h7e
`define FMCR_IDX_TEST_B      8'h7f
`define FMCR_IDX_LOCK        8'h80
`define FMCR_RST_FMT_DRIVE   8'h00
`define FMCR_RST_PIN_SCALE   8'h00
`define FMCR_RST_TEST        8'h00
`define FMCR_FMT_WMASK       8'h0f
`define FMCR_BIT_TEMP_FMT    0
`define FMCR_BIT_DRIVE_FREQ  1
`define FMCR_BIT_PIN_DIR     2
`define FMCR_BIT_PIN_POL     3
`define FMCR_BIT_ATTEN_LO    4
`endif

// ---- verilog/fmcr_pin_ctrl.sv ----
// Drives the shared pin from its selected function.
// Assumes the function sources arrive synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module fmcr_pin_ctrl (
	// Configuration
	input  wire logic [1:0] i_pin_fn,
	input  wire logic       i_pin_dir,
	input  wire logic       i_pin_pol,
	// Function sources
	input  wire logic       i_gp_level,
	input  wire logic       i_alert_level,
	input  wire logic       i_thermal_drive,
	input  wire logic       i_pin_in,
	// Pin and results
	output logic            o_pin_out,
	output logic            o_pin_oe,
	output logic            o_gp_in,
	output logic            o_fan4_in
);
	always_comb begin
		o_pin_out = 1'b0;
		o_pin_oe  = 1'b0;
		o_gp_in   = 1'b0;
		o_fan4_in = 1'b0;
		unique case (fmcr_pkg::fmcr_pin_fn_t'(i_pin_fn))
			fmcr_pkg::FMCR_PIN_FAN4: begin
				o_fan4_in = i_pin_in;
			end
			fmcr_pkg::FMCR_PIN_THERMAL: begin
				// Open-drain, low asserts
				o_pin_oe = i_thermal_drive;
			end
			fmcr_pkg::FMCR_PIN_ALERT: begin
				o_pin_oe = i_alert_level;
			end
			fmcr_pkg::FMCR_PIN_GENERAL: begin
				o_pin_oe  = i_pin_dir;
				// Level only meaningful while driving
				o_pin_out = i_pin_dir & (i_pin_pol ? i_gp_level : ~i_gp_level);
				o_gp_in   = i_pin_dir ? 1'b0 : i_pin_in;
			end
		endcase
	end
endmodule : fmcr_pin_ctrl
`default_nettype wire

// ---- verilog/fmcr_pkg.sv ----
// Types for the fan monitor configuration register slice.
// Assumes nothing beyond the map header.
package fmcr_pkg;
	typedef enum logic [1:0] {
		FMCR_PIN_FAN4,
		FMCR_PIN_THERMAL,
		FMCR_PIN_ALERT,
		FMCR_PIN_GENERAL
	} fmcr_pin_fn_t;
	typedef enum logic {
		FMCR_DRV_HIGH,
		FMCR_DRV_LOW
	} fmcr_drive_t;
endpackage : fmcr_pkg

// ---- verilog/fmcr_regs.sv ----
// Configuration register slice with APB slave, lock and shared pin.
// Assumes one clock; the lock is a register of this slice.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "fmcr_map.svh"
module fmcr_regs #(
	parameter int TEMP_N = 3
) (
	// Clock and reset
	input  wire logic              i_ref_clk,
	input  wire logic              i_reset_n,
	// APB
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [11:0]       i_paddr,
	input  wire logic [31:0]       i_pwdata,
	input  wire logic [3:0]        i_pstrb,
	output logic                   o_pready,
	output logic                   o_pslverr,
	output logic      [31:0]       o_prdata,
	// Temperatures, stored two's complement
	input  wire logic [TEMP_N*8-1:0] i_temp_raw,
	output logic      [TEMP_N*8-1:0] o_temp_view,
	// Configuration outputs
	output logic                   o_drive_low_freq,
	output logic      [1:0]        o_two_wire_sense_threshold,
	output logic                   o_threshold_active,
	output logic      [3:0]        o_bypass_atten,
	// Shared pin and sources
	input  wire logic              i_gp_level,
	input  wire logic              i_alert_level,
	input  wire logic              i_thermal_drive,
	input  wire logic              i_pin_in,
	output logic                   o_pin_out,
	output logic                   o_pin_oe,
	output logic                   o_gp_in,
	output logic                   o_fan4_in
);
	typedef struct packed {
		logic [7:0]  fmt;
		logic [7:0]  pin;
		logic        lock;
		logic [31:0] rdata;
	} fmcr_state_t;

	fmcr_state_t s_q;
	fmcr_state_t s_d;

	function automatic logic [7:0] fmcr_index(input logic [11:0] a);
		fmcr_index = a[9:2];
	endfunction

	logic       wr_take;
	logic       rd_take;
	logic [7:0] idx;
	logic       known;

	assign idx     = fmcr_index(i_paddr);
	assign known   = (i_paddr[1:0] == 2'h0) && (i_paddr[11:10] == 2'h0)
		&& (idx >= `FMCR_IDX_FMT_DRIVE) && (idx <= `FMCR_IDX_LOCK);
	assign wr_take = i_psel && i_penable && i_pwrite && i_pstrb[0] && known;
	// Read captured in setup phase so data stands at the access edge
	assign rd_take = i_psel && !i_penable && !i_pwrite;

	// Register image mux, used only by read data capture
	logic [31:0] rd_now;
	always_comb begin
		unique case (idx)
			`FMCR_IDX_FMT_DRIVE: rd_now = {24'h0, s_q.fmt};
			`FMCR_IDX_PIN_SCALE: rd_now = {24'h0, s_q.pin};
			`FMCR_IDX_TEST_A:    rd_now = {24'h0, `FMCR_RST_TEST};
			`FMCR_IDX_TEST_B:    rd_now = {24'h0, `FMCR_RST_TEST};
			`FMCR_IDX_LOCK:      rd_now = {31'h0, s_q.lock};
			default:             rd_now = 32'h0;
		endcase
	end

	always_comb begin
		s_d = s_q;
		if (wr_take && !s_q.lock) begin
			unique case (idx)
				`FMCR_IDX_FMT_DRIVE: begin
					s_d.fmt = i_pwdata[7:0] & `FMCR_FMT_WMASK;
				end
				`FMCR_IDX_PIN_SCALE: begin
					s_d.pin = i_pwdata[7:0];
				end
				`FMCR_IDX_LOCK: begin
					// Sticky until reset, so lock cannot be undone
					s_d.lock = i_pwdata[0];
				end
				default: begin
				end
			endcase
		end
		if (rd_take) begin
			// Unmapped reads return zero
			s_d.rdata = known ? rd_now : 32'h0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_q <= '{fmt: `FMCR_RST_FMT_DRIVE, pin: `FMCR_RST_PIN_SCALE, lock: 1'b0, rdata: 32'h0};
		end else begin
			s_q <= s_d;
		end
	end

	// Zero-wait slave; read data flopped at setup, valid in access phase
	always_comb begin
		o_pready  = 1'b1;
		o_pslverr = i_psel && i_penable && !known;
		o_prdata  = s_q.rdata;
	end

	assign o_drive_low_freq = s_q.fmt[`FMCR_BIT_DRIVE_FREQ];
	assign o_two_wire_sense_threshold = s_q.pin[3:2];
	assign o_threshold_active = s_q.fmt[`FMCR_BIT_DRIVE_FREQ];
	assign o_bypass_atten = s_q.pin[7:`FMCR_BIT_ATTEN_LO];

	genvar g;
	generate
		for (g = 0; g < TEMP_N; g++) begin : g_temp
			fmcr_temp_view u_view (
				.i_twos_comp (s_q.fmt[`FMCR_BIT_TEMP_FMT]),
				.i_raw       (i_temp_raw[g*8 +: 8]),
				.o_view      (o_temp_view[g*8 +: 8])
			);
		end
	endgenerate

	fmcr_pin_ctrl u_pin (
		.i_pin_fn        (s_q.pin[1:0]),
		.i_pin_dir       (s_q.fmt[`FMCR_BIT_PIN_DIR]),
		.i_pin_pol       (s_q.fmt[`FMCR_BIT_PIN_POL]),
		.i_gp_level      (i_gp_level),
		.i_alert_level   (i_alert_level),
		.i_thermal_drive (i_thermal_drive),
		.i_pin_in        (i_pin_in),
		.o_pin_out       (o_pin_out),
		.o_pin_oe        (o_pin_oe),
		.o_gp_in         (o_gp_in),
		.o_fan4_in       (o_fan4_in)
	);

	// Assertions
	AST_LOCK_HOLDS: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		s_q.lock |=> ($stable(s_q.fmt) && $stable(s_q.pin)))
		else $error("Locked configuration changed");
	AST_FMT_UPPER: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		s_q.fmt[7:4] == 4'h0)
		else $error("Unused format bits set");
	AST_WRITE_LANDS: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(wr_take && !s_q.lock && idx == `FMCR_IDX_PIN_SCALE) |=> s_q.pin == $past(i_pwdata[7:0]))
		else $error("Pin config write lost");
	AST_DRIVE: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		o_drive_low_freq == s_q.fmt[1] && o_threshold_active == o_drive_low_freq)
		else $error("Drive select mismatch");
	AST_TEMP: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!s_q.fmt[0] |-> o_temp_view[7:0] == 8'(i_temp_raw[7:0] + 8'h40))
		else $error("Offset format wrong");
	AST_TEMP_SWITCH: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		$rose(s_q.fmt[0]) |-> o_temp_view == i_temp_raw)
		else $error("Temperatures not reinterpreted");
	AST_GP_DIR: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(s_q.pin[1:0] == 2'h3) |-> o_pin_oe == s_q.fmt[2])
		else $error("General pin direction wrong");
	AST_GP_POL: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(s_q.pin[1:0] == 2'h3 && s_q.fmt[2]) |-> o_pin_out == (i_gp_level ~^ s_q.fmt[3]))
		else $error("General pin polarity wrong");
	AST_FAN4: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(s_q.pin[1:0] == 2'h0) |-> (!o_pin_oe && o_fan4_in == i_pin_in))
		else $error("Fan4 input routing wrong");
	AST_TEST_RO: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(rd_take && idx == `FMCR_IDX_TEST_A) |=> o_prdata == 32'h0)
		else $error("Test register not zero");
	AST_RD_PIN: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		(rd_take && idx == `FMCR_IDX_PIN_SCALE && known) |=> o_prdata == {24'h0, $past(s_q.pin)})
		else $error("Pin config read wrong");
	COV_LOCK: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) $rose(s_q.lock));
	COV_GP_OUT: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) s_q.pin[1:0] == 2'h3 && o_pin_oe);
	COV_FMT: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) $fell(s_q.fmt[0]));
	COV_BLOCKED: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) wr_take && s_q.lock);

endmodule : fmcr_regs
`default_nettype wire

// ---- verilog/fmcr_temp_view.sv ----
// Converts one stored temperature byte to the selected format.
// Assumes stored bytes are kept in two's complement.
`timescale 1ns/1ps
`default_nettype none
module fmcr_temp_view (
	// Stored value and format
	input  wire logic       i_twos_comp,
	input  wire logic [7:0] i_raw,
	// Presented value
	output logic      [7:0] o_view
);
	always_comb begin
		o_view = i_twos_comp ? i_raw : 8'(i_raw + 8'h40);
	end
endmodule : fmcr_temp_view
`default_nettype wire
